// *** timer2_async_pkg.sv ***
// Shared constants and types for the asynchronous timer clocking block.
package timer2_async_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ASYNC_STATUS_OFFSET = 8'h40;
  localparam logic [7:0] GENERAL_CTRL_OFFSET = 8'h44;
  localparam logic [7:0] COUNTER_OFFSET = 8'h48;
  localparam logic [7:0] COMPARE_A_OFFSET = 8'h4c;
  localparam logic [7:0] COMPARE_B_OFFSET = 8'h50;
  localparam logic [7:0] TIMER_CTRL_OFFSET = 8'h54;
  localparam logic [7:0] IRQ_FLAGS_OFFSET = 8'h58;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h70;

  // ==========================================================================
  // Field positions
  localparam int ALT_PIN_BIT = 6;
  localparam int ASYNC_SEL_BIT = 5;
  localparam int EXT_CLK_BIT = 4;
  localparam int PRESCALER_RESET_BIT = 0;
  localparam int TOGGLE_A_BIT = 3;
  localparam int TOGGLE_B_BIT = 4;
  localparam int OVERFLOW_BIT = 0;
  localparam int COMPARE_A_BIT = 1;
  localparam int COMPARE_B_BIT = 2;
  localparam int BUSY_COUNTER = 0;
  localparam int BUSY_COMPARE_A = 1;
  localparam int BUSY_COMPARE_B = 2;
  localparam int BUSY_CONTROL = 3;

  // ==========================================================================
  // Reset values
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [2:0] FLAGS_RESET = 3'h0;

  // ==========================================================================
  // Clock-select codes and prescaler
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam int PRESCALE_W = 10;

  // ==========================================================================
  // Sleep mode codes
  localparam logic [2:0] SLEEP_IDLE = 3'h0;
  localparam logic [2:0] SLEEP_NOISE_REDUCTION = 3'h1;
  localparam logic [2:0] SLEEP_POWER_DOWN = 3'h2;
  localparam logic [2:0] SLEEP_POWER_SAVE = 3'h3;
  localparam logic [2:0] SLEEP_STANDBY = 3'h6;

  // ==========================================================================
  // Cycle counts
  localparam logic [2:0] STALL_CYCLES = 3'h4;
  localparam logic [1:0] TRANSFER_EDGES = 2'h2;
  localparam int FLAG_SYNC_STAGES = 2;

  typedef enum logic [1:0] {WAKE_RUN, WAKE_ARMED, WAKE_STALL, WAKE_VECTOR} wake_state_t;

endpackage : timer2_async_pkg

// *** timer_prescaler.sv ***
// Prescaler that divides the timer source tick by the selected ratio.
`timescale 1ns/1ns
`default_nettype none
module timer_prescaler
  import timer2_async_pkg::*;
#(
  parameter int WIDTH = timer2_async_pkg::PRESCALE_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic src_tick,
  input wire logic clear,
  input wire logic [2:0] clock_sel,
  // Divided tick
  output logic count_tick
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } pre_state_t;

  pre_state_t s_reg;
  pre_state_t s_next;

  // ==========================================================================
  // Tap selection
  function automatic logic [WIDTH-1:0] tap_mask(input logic [2:0] cs);
    case (cs)
      CS_DIV8: tap_mask = WIDTH'(10'h007);
      CS_DIV32: tap_mask = WIDTH'(10'h01f);
      CS_DIV64: tap_mask = WIDTH'(10'h03f);
      CS_DIV128: tap_mask = WIDTH'(10'h07f);
      CS_DIV256: tap_mask = WIDTH'(10'h0ff);
      default: tap_mask = WIDTH'(10'h3ff);
    endcase
  endfunction : tap_mask

  always_comb begin
    s_next = s_reg;
    count_tick = 1'b0;
    if (clock_sel == CS_DIV1) begin
      count_tick = src_tick;
    end else if (clock_sel != CS_STOP) begin
      count_tick = src_tick && ((s_reg.cnt & tap_mask(clock_sel)) == tap_mask(clock_sel));
    end
    if (clear) begin
      s_next.cnt = '0;
      count_tick = 1'b0;
    end else if (src_tick) begin
      s_next.cnt = s_reg.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : timer_prescaler
`default_nettype wire

// *** timer2_async.sv ***
// Asynchronous clocking, prescaling, crossing and interrupt mask of the 8-bit timer.
//
// Function
// - Crystal runs in sleep except deep modes.
// - Deep-sleep wake-up clears counter, compares, control.
// - Wake-up starts on next timer tick.
// - Stall four cycles, then start vector.
// - Counter reads use copy updated per edge.
// - After power-save, old value until edge.
// - Flag crossing: three cycles plus one tick.
// - Compare pins change on timer tick only.
// - Default I/O clock; async bit selects pins.
// - Crystal mode enables oscillator, takes pins.
// - External clock on oscillator pin, crystal off.
// - Alternate pin clocks; crystal kept unless external.
// - Clock select: stop, 1, 8..1024.
// - Prescaler reset bit clears prescaler.
// - Mask bits 7..3 read zero.
// - Compare B request: mask, enable, flag.
// - Compare A request: mask, enable, flag.
// - Overflow request: mask, enable, flag.
// - Async writes land after two edges.
// - Overflow flag set; cleared by vector/write-one.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module timer2_async
  import timer2_async_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pins
  input wire logic osc_input_pin,
  input wire logic alternate_clock_pin,
  output logic osc_enable,
  output logic osc_input_taken,
  output logic osc_output_taken,
  output logic alt_pin_taken,
  // Compare output pins
  output logic compare_a_pin,
  output logic compare_b_pin,
  // Processor side
  input wire logic global_irq_enable,
  input wire logic [2:0] irq_ack,
  input wire logic sleep_active,
  input wire logic [2:0] sleep_mode,
  output logic [2:0] irq_request,
  output logic wake_request,
  output logic cpu_stall,
  output logic vector_start
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] mask;
    logic async_sel;
    logic ext_sel;
    logic alt_sel;
    logic [7:0] counter;
    logic [7:0] copy;
    logic [7:0] comp_a;
    logic [7:0] comp_b;
    logic [4:0] ctrl;
    logic [7:0] tmp_counter;
    logic [7:0] tmp_comp_a;
    logic [7:0] tmp_comp_b;
    logic [4:0] tmp_ctrl;
    logic [3:0] pend;
    logic [3:0][1:0] pend_cnt;
    logic [2:0] flags;
    logic [FLAG_SYNC_STAGES-1:0][2:0] flag_pipe;
    logic osc_prev;
    logic alt_prev;
    logic psr_req;
    logic [2:0] irq;
    logic osc_en;
    logic osc_in_taken;
    logic osc_out_taken;
    logic alt_taken;
    logic cmp_a_pin;
    logic cmp_b_pin;
    logic sleep_prev;
    logic [2:0] sleep_mode_prev;
    wake_state_t wake;
    logic [2:0] stall_cnt;
    logic wake_req;
    logic stall;
    logic vec;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic osc_rise;
  logic alt_rise;
  logic async_edge;
  logic deep_sleep;
  logic undefined_sel;
  logic src_tick;
  logic count_tick;
  logic setup;
  logic wr;
  logic [3:0] commit;
  logic [2:0] events;
  logic [2:0] clr;
  logic [2:0] set_flags;
  logic [31:0] rdata;
  logic hit;
  logic [7:0] wbyte;

  // ==========================================================================
  // Source clock selection
  always_comb begin
    osc_rise = osc_input_pin && !s_reg.osc_prev;
    alt_rise = alternate_clock_pin && !s_reg.alt_prev;
    async_edge = s_reg.alt_sel ? alt_rise : osc_rise;
    deep_sleep = sleep_active && (sleep_mode == SLEEP_POWER_DOWN || sleep_mode == SLEEP_STANDBY);
    undefined_sel = !s_reg.async_sel && s_reg.ext_sel;
    if (undefined_sel) begin
      src_tick = 1'b0;
    end else if (s_reg.async_sel) begin
      src_tick = async_edge && !deep_sleep;
    end else begin
      src_tick = 1'b1;
    end
  end

  timer_prescaler #(
    .WIDTH(PRESCALE_W)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .clear(s_reg.psr_req),
    .clock_sel(s_reg.ctrl[2:0]),
    .count_tick(count_tick)
  );

  // ==========================================================================
  // Register read decode
  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == ASYNC_STATUS_OFFSET) begin
      rdata[ALT_PIN_BIT] = s_reg.alt_sel;
      rdata[ASYNC_SEL_BIT] = s_reg.async_sel;
      rdata[EXT_CLK_BIT] = s_reg.ext_sel;
      rdata[3:0] = s_reg.pend;
    end else if (paddr == GENERAL_CTRL_OFFSET) begin
      rdata = 32'h0000_0000;
    end else if (paddr == COUNTER_OFFSET) begin
      rdata[7:0] = s_reg.copy;
    end else if (paddr == COMPARE_A_OFFSET) begin
      rdata[7:0] = s_reg.comp_a;
    end else if (paddr == COMPARE_B_OFFSET) begin
      rdata[7:0] = s_reg.comp_b;
    end else if (paddr == TIMER_CTRL_OFFSET) begin
      rdata[4:0] = s_reg.ctrl;
    end else if (paddr == IRQ_FLAGS_OFFSET) begin
      rdata[2:0] = s_reg.flags;
    end else if (paddr == IRQ_MASK_OFFSET) begin
      rdata[2:0] = s_reg.mask;
    end else begin
      hit = 1'b0;
    end
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    setup = psel && penable && !s_reg.pready;
    wr = psel && penable && s_reg.pready && pwrite && !s_reg.pslverr;
    wbyte = pwdata[7:0];
    commit = 4'h0;
    events = 3'h0;
    clr = 3'h0;
    set_flags = 3'h0;

    // APB handshake with one wait state.
    s_next.pready = setup;
    s_next.pslverr = setup && !hit;
    if (setup) begin
      s_next.prdata = rdata;
    end

    s_next.osc_prev = osc_input_pin;
    s_next.alt_prev = alternate_clock_pin;
    s_next.psr_req = 1'b0;

    // Pending transfers count selected async source edges, then land.
    for (int i = 0; i < 4; i++) begin
      if (s_reg.pend[i] && async_edge) begin
        if (s_reg.pend_cnt[i] == TRANSFER_EDGES - 2'h1) begin
          commit[i] = 1'b1;
          s_next.pend[i] = 1'b0;
          s_next.pend_cnt[i] = 2'h0;
        end else begin
          s_next.pend_cnt[i] = s_reg.pend_cnt[i] + 2'h1;
        end
      end
    end

    // Counting on the divided timer tick.
    if (count_tick) begin
      s_next.counter = s_reg.counter + 8'h01;
      events[OVERFLOW_BIT] = s_reg.counter == 8'hff;
      if (s_reg.counter == s_reg.comp_a && !s_reg.pend[BUSY_COMPARE_A]) begin
        events[COMPARE_A_BIT] = 1'b1;
        if (s_reg.ctrl[TOGGLE_A_BIT]) begin
          s_next.cmp_a_pin = !s_reg.cmp_a_pin;
        end
      end
      if (s_reg.counter == s_reg.comp_b && !s_reg.pend[BUSY_COMPARE_B]) begin
        events[COMPARE_B_BIT] = 1'b1;
        if (s_reg.ctrl[TOGGLE_B_BIT]) begin
          s_next.cmp_b_pin = !s_reg.cmp_b_pin;
        end
      end
    end
    if (commit[BUSY_COUNTER]) begin
      s_next.counter = s_reg.tmp_counter;
    end
    if (commit[BUSY_COMPARE_A]) begin
      s_next.comp_a = s_reg.tmp_comp_a;
    end
    if (commit[BUSY_COMPARE_B]) begin
      s_next.comp_b = s_reg.tmp_comp_b;
    end
    if (commit[BUSY_CONTROL]) begin
      s_next.ctrl = s_reg.tmp_ctrl;
    end

    // Counter copy seen by the bus.
    if (!s_reg.async_sel) begin
      s_next.copy = s_reg.counter;
    end else if (osc_rise) begin
      s_next.copy = s_reg.counter;
    end

    // Register writes.
    if (wr) begin
      if (paddr == ASYNC_STATUS_OFFSET) begin
        s_next.alt_sel = wbyte[ALT_PIN_BIT];
        s_next.async_sel = wbyte[ASYNC_SEL_BIT];
        s_next.ext_sel = wbyte[EXT_CLK_BIT];
      end else if (paddr == GENERAL_CTRL_OFFSET) begin
        s_next.psr_req = wbyte[PRESCALER_RESET_BIT];
      end else if (paddr == COUNTER_OFFSET) begin
        if (s_reg.async_sel) begin
          s_next.tmp_counter = wbyte;
          s_next.pend[BUSY_COUNTER] = 1'b1;
          s_next.pend_cnt[BUSY_COUNTER] = 2'h0;
        end else begin
          s_next.counter = wbyte;
        end
      end else if (paddr == COMPARE_A_OFFSET) begin
        if (s_reg.async_sel) begin
          s_next.tmp_comp_a = wbyte;
          s_next.pend[BUSY_COMPARE_A] = 1'b1;
          s_next.pend_cnt[BUSY_COMPARE_A] = 2'h0;
        end else begin
          s_next.comp_a = wbyte;
        end
      end else if (paddr == COMPARE_B_OFFSET) begin
        if (s_reg.async_sel) begin
          s_next.tmp_comp_b = wbyte;
          s_next.pend[BUSY_COMPARE_B] = 1'b1;
          s_next.pend_cnt[BUSY_COMPARE_B] = 2'h0;
        end else begin
          s_next.comp_b = wbyte;
        end
      end else if (paddr == TIMER_CTRL_OFFSET) begin
        if (s_reg.async_sel) begin
          s_next.tmp_ctrl = wbyte[4:0];
          s_next.pend[BUSY_CONTROL] = 1'b1;
          s_next.pend_cnt[BUSY_CONTROL] = 2'h0;
        end else begin
          s_next.ctrl = wbyte[4:0];
        end
      end else if (paddr == IRQ_FLAGS_OFFSET) begin
        clr = wbyte[2:0];
      end else if (paddr == IRQ_MASK_OFFSET) begin
        s_next.mask = wbyte[2:0];
      end
    end

    // Flag crossing: tick-time events pass a pipeline in async mode.
    s_next.flag_pipe[0] = events;
    for (int k = 1; k < FLAG_SYNC_STAGES; k++) begin
      s_next.flag_pipe[k] = s_reg.flag_pipe[k-1];
    end
    set_flags = s_reg.async_sel ? s_reg.flag_pipe[FLAG_SYNC_STAGES-1] : events;
    clr = clr | irq_ack;
    s_next.flags = (s_reg.flags & ~clr) | set_flags;

    // Requests gated by mask and global enable.
    s_next.irq[COMPARE_B_BIT] = s_reg.mask[COMPARE_B_BIT] && global_irq_enable && s_reg.flags[COMPARE_B_BIT];
    s_next.irq[COMPARE_A_BIT] = s_reg.mask[COMPARE_A_BIT] && global_irq_enable && s_reg.flags[COMPARE_A_BIT];
    s_next.irq[OVERFLOW_BIT] = s_reg.mask[OVERFLOW_BIT] && global_irq_enable && s_reg.flags[OVERFLOW_BIT];

    // Oscillator and pin ownership.
    s_next.osc_en = s_reg.async_sel && !s_reg.ext_sel && !deep_sleep;
    s_next.osc_in_taken = s_reg.async_sel && !(s_reg.alt_sel && s_reg.ext_sel);
    s_next.osc_out_taken = s_reg.async_sel && !s_reg.ext_sel;
    s_next.alt_taken = s_reg.async_sel && s_reg.alt_sel;

    // Sleep tracking and deep-sleep wake-up loss.
    s_next.sleep_prev = sleep_active;
    s_next.sleep_mode_prev = sleep_mode;
    if (s_reg.sleep_prev && !sleep_active &&
        (s_reg.sleep_mode_prev == SLEEP_POWER_DOWN || s_reg.sleep_mode_prev == SLEEP_STANDBY)) begin
      s_next.counter = BYTE_RESET;
      s_next.copy = BYTE_RESET;
      s_next.comp_a = BYTE_RESET;
      s_next.comp_b = BYTE_RESET;
      s_next.ctrl = CTRL_RESET;
      s_next.pend = 4'h0;
      s_next.pend_cnt = '0;
    end

    // Wake-up sequence.
    s_next.wake_req = 1'b0;
    s_next.vec = 1'b0;
    case (s_reg.wake)
      WAKE_RUN: begin
        if (sleep_active && s_reg.async_sel &&
            (sleep_mode == SLEEP_POWER_SAVE || sleep_mode == SLEEP_NOISE_REDUCTION) &&
            global_irq_enable && ((s_reg.mask & (s_reg.flags | set_flags)) != 3'h0)) begin
          s_next.wake = WAKE_ARMED;
        end
      end
      WAKE_ARMED: begin
        if (src_tick) begin
          s_next.wake = WAKE_STALL;
          s_next.wake_req = 1'b1;
          s_next.stall = 1'b1;
          s_next.stall_cnt = STALL_CYCLES;
        end
      end
      WAKE_STALL: begin
        if (s_reg.stall_cnt == 3'h1) begin
          s_next.stall = 1'b0;
          s_next.vec = 1'b1;
          s_next.wake = WAKE_VECTOR;
        end
        s_next.stall_cnt = s_reg.stall_cnt - 3'h1;
      end
      default: begin
        s_next.wake = WAKE_RUN;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.mask <= MASK_RESET;
      s_reg.flags <= FLAGS_RESET;
      s_reg.wake <= WAKE_RUN;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign osc_enable = s_reg.osc_en;
  assign osc_input_taken = s_reg.osc_in_taken;
  assign osc_output_taken = s_reg.osc_out_taken;
  assign alt_pin_taken = s_reg.alt_taken;
  assign compare_a_pin = s_reg.cmp_a_pin;
  assign compare_b_pin = s_reg.cmp_b_pin;
  assign irq_request = s_reg.irq;
  assign wake_request = s_reg.wake_req;
  assign cpu_stall = s_reg.stall;
  assign vector_start = s_reg.vec;

endmodule : timer2_async
`default_nettype wire

// *** timer2_async_properties.sv ***
// Concurrent checks on the ports of the asynchronous timer block.
`timescale 1ns/1ns
`default_nettype none
module timer2_async_props
  import timer2_async_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Clock pins
  input wire logic osc_enable,
  input wire logic osc_output_taken,
  // Processor side
  input wire logic global_irq_enable,
  input wire logic sleep_active,
  input wire logic [2:0] sleep_mode,
  input wire logic [2:0] irq_request,
  input wire logic wake_request,
  input wire logic cpu_stall,
  input wire logic vector_start
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Sequences
  sequence stall_four;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence

  // ==========================================================================
  // Properties
  property osc_pins_paired;
    osc_output_taken != osc_enable |-> $past(sleep_active) &&
      ($past(sleep_mode) == SLEEP_POWER_DOWN || $past(sleep_mode) == SLEEP_STANDBY);
  endproperty

  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_access_answer: assert property ($rose(penable) && psel |=> pready)
    else $error("ready missing one cycle after access");
  a_ready_needs_access: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready without an access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_irq_gie_gate: assert property (!global_irq_enable |=> irq_request == 3'h0)
    else $error("request raised while interrupts disabled");
  a_osc_pin_pair: assert property (osc_pins_paired)
    else $error("oscillator output pin use differs from oscillator state");
  a_wake_then_stall: assert property (wake_request |-> $rose(cpu_stall))
    else $error("stall did not start with wake");
  a_stall_length: assert property ($rose(cpu_stall) |-> stall_four ##[0:1] vector_start)
    else $error("stall length or vector start wrong");
  a_wake_pulse_once: assert property (wake_request |=> !wake_request)
    else $error("wake longer than one cycle");
  a_wake_in_sleep: assert property (wake_request |-> sleep_active)
    else $error("wake outside sleep");
  a_vector_pulse_once: assert property (vector_start |=> !vector_start)
    else $error("vector start longer than one cycle");
endmodule : timer2_async_props

bind timer2_async timer2_async_props props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .osc_enable(osc_enable),
  .osc_output_taken(osc_output_taken), .global_irq_enable(global_irq_enable),
  .sleep_active(sleep_active), .sleep_mode(sleep_mode), .irq_request(irq_request),
  .wake_request(wake_request),
  .cpu_stall(cpu_stall), .vector_start(vector_start));
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the asynchronous timer block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import timer2_async_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, osc_input_pin = 1'b0, alt_clk = 1'b0;
  logic global_irq_enable = 1'b0, sleep_active = 1'b0, err, woke;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [2:0] irq_ack = 3'h0, sleep_mode = 3'h0, irq_request;
  logic pready, pslverr, osc_enable, osc_input_taken, osc_output_taken, alt_pin_taken;
  logic compare_a_pin, compare_b_pin, wake_request, cpu_stall, vector_start;
  int error_cnt = 0, samples_checked = 0, n, k, stalls;
  int dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [2:0] cfg [6] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h5, 3'h7};
  logic [3:0] pins [6] = '{4'h0, 4'h0, 4'he, 4'h4, 4'hf, 4'h1};

  always #20 pclk = ~pclk;

  timer2_async uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_input_pin(osc_input_pin), .alternate_clock_pin(alt_clk),
    .osc_enable(osc_enable), .osc_input_taken(osc_input_taken),
    .osc_output_taken(osc_output_taken), .alt_pin_taken(alt_pin_taken),
    .compare_a_pin(compare_a_pin), .compare_b_pin(compare_b_pin),
    .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .sleep_active(sleep_active),
    .sleep_mode(sleep_mode), .irq_request(irq_request), .wake_request(wake_request),
    .cpu_stall(cpu_stall), .vector_start(vector_start));

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 20) begin
      t++;
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) chk(32'h0, 32'h1, "bus timeout");
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask : rd

  task automatic osc_edge(input int cnt, input logic alt = 1'b0);
    repeat (cnt) begin
      @(posedge pclk);
      if (alt) begin
        alt_clk <= 1'b1;
      end else begin
        osc_input_pin <= 1'b1;
      end
      cyc(4);
      alt_clk <= 1'b0;
      osc_input_pin <= 1'b0;
      cyc(4);
    end
  endtask : osc_edge

  task automatic stop_test;
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Watchdog
  initial begin : watchdog
    cyc(40000);
    error_cnt++;
    stop_test();
  end

  // ==========================================================================
  // Tests
  initial begin : main
    cyc(20);
    presetn <= 1'b1;
    rd(IRQ_MASK_OFFSET, 32'h0, "mask reset");
    apb(1'b1, IRQ_MASK_OFFSET, 32'hff);
    rd(IRQ_MASK_OFFSET, 32'h7, "mask reserved bits");
    apb(1'b0, 8'h7c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    for (k = 0; k < 6; k++) begin
      apb(1'b1, ASYNC_STATUS_OFFSET, {25'h0, cfg[k][0], cfg[k][2], cfg[k][1], 4'h0});
      cyc(2);
      chk({28'h0, osc_enable, osc_input_taken, osc_output_taken, alt_pin_taken},
        {28'h0, pins[k]}, "clock pins");
    end
    apb(1'b1, ASYNC_STATUS_OFFSET, 32'h0);
    for (k = 0; k < 8; k++) begin
      if (k != 1) begin
        apb(1'b1, TIMER_CTRL_OFFSET, 32'h0);
        apb(1'b1, COUNTER_OFFSET, 32'h0);
        apb(1'b1, GENERAL_CTRL_OFFSET, 32'h1);
        apb(1'b1, TIMER_CTRL_OFFSET, 32'(k));
        cyc(k == 0 ? 50 : 3 * dv[k] + dv[k] / 4 - 3);
        apb(1'b1, TIMER_CTRL_OFFSET, 32'h0);
        rd(COUNTER_OFFSET, k == 0 ? 32'h0 : 32'h3, "prescaled count");
      end
    end
    apb(1'b1, COMPARE_A_OFFSET, 32'h10);
    apb(1'b1, COMPARE_B_OFFSET, 32'h20);
    apb(1'b1, IRQ_FLAGS_OFFSET, 32'h7);
    apb(1'b1, COUNTER_OFFSET, 32'h0);
    apb(1'b1, TIMER_CTRL_OFFSET, 32'h19);
    cyc(258);
    apb(1'b1, TIMER_CTRL_OFFSET, 32'h18);
    rd(IRQ_FLAGS_OFFSET, 32'h7, "flags set");
    chk({30'h0, compare_b_pin, compare_a_pin}, 32'h3, "toggle pins");
    global_irq_enable <= 1'b1;
    for (k = 0; k < 8; k++) begin
      apb(1'b1, IRQ_MASK_OFFSET, 32'(k));
      cyc(2);
      chk({29'h0, irq_request}, 32'(k), "irq request");
    end
    global_irq_enable <= 1'b0;
    cyc(2);
    chk({29'h0, irq_request}, 32'h0, "irq gated");
    irq_ack <= 3'h1;
    cyc(1);
    irq_ack <= 3'h0;
    rd(IRQ_FLAGS_OFFSET, 32'h6, "ack clears");
    apb(1'b1, IRQ_FLAGS_OFFSET, 32'h2);
    rd(IRQ_FLAGS_OFFSET, 32'h4, "write one clears");
    apb(1'b1, ASYNC_STATUS_OFFSET, 32'h10);
    apb(1'b1, COUNTER_OFFSET, 32'h44);
    apb(1'b1, TIMER_CTRL_OFFSET, 32'h1);
    cyc(20);
    apb(1'b1, TIMER_CTRL_OFFSET, 32'h18);
    rd(COUNTER_OFFSET, 32'h44, "undefined source");
    apb(1'b1, ASYNC_STATUS_OFFSET, 32'h60);
    apb(1'b1, COMPARE_B_OFFSET, 32'h33);
    osc_edge(2);
    rd(ASYNC_STATUS_OFFSET, 32'h64, "alt busy held");
    osc_edge(2, 1'b1);
    rd(COMPARE_B_OFFSET, 32'h33, "alt pin landed");
    apb(1'b1, ASYNC_STATUS_OFFSET, 32'h20);
    apb(1'b1, COUNTER_OFFSET, 32'h5a);
    rd(ASYNC_STATUS_OFFSET, 32'h21, "busy set");
    osc_edge(3);
    rd(ASYNC_STATUS_OFFSET, 32'h20, "busy clear");
    rd(COUNTER_OFFSET, 32'h5a, "synced copy");
    apb(1'b1, IRQ_FLAGS_OFFSET, 32'h7);
    apb(1'b1, TIMER_CTRL_OFFSET, 32'h1);
    apb(1'b1, COUNTER_OFFSET, 32'hfe);
    osc_edge(6);
    rd(IRQ_FLAGS_OFFSET, 32'h1, "async overflow");
    apb(1'b1, IRQ_MASK_OFFSET, 32'h1);
    global_irq_enable <= 1'b1;
    sleep_mode <= SLEEP_POWER_SAVE;
    sleep_active <= 1'b1;
    woke = 1'b0;
    for (n = 0; n < 10; n++) begin
      @(negedge pclk);
      woke = woke | (wake_request === 1'b1);
    end
    chk({31'h0, woke}, 32'h0, "wake before tick");
    chk({31'h0, osc_enable}, 32'h1, "oscillator in sleep");
    @(posedge pclk);
    osc_input_pin <= 1'b1;
    stalls = 0;
    n = 0;
    @(negedge pclk);
    while (vector_start !== 1'b1 && n < 40) begin
      stalls += (cpu_stall === 1'b1);
      n++;
      @(negedge pclk);
    end
    chk(32'(stalls), 32'h4, "stall cycles");
    chk({31'h0, vector_start}, 32'h1, "vector start");
    @(posedge pclk);
    osc_input_pin <= 1'b0;
    sleep_active <= 1'b0;
    irq_ack <= 3'h1;
    cyc(1);
    irq_ack <= 3'h0;
    sleep_mode <= SLEEP_POWER_DOWN;
    sleep_active <= 1'b1;
    cyc(5);
    sleep_active <= 1'b0;
    cyc(3);
    rd(COUNTER_OFFSET, 32'h0, "deep wake counter");
    rd(COMPARE_A_OFFSET, 32'h0, "deep wake compare");
    stop_test();
  end
endmodule : tb
`default_nettype wire
